// ==== hw/rim_relay_input_mapper.sv ====
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps

module rim_relay_input_mapper
    import rim_pkg::*;
#(
    parameter int N_RELAY = RIM_NFUNC,
    parameter int N_INPUT = RIM_NFUNC,
    parameter int N_SRC_OUT = RIM_SRC_OUTS,
    parameter int N_SNS_SHUT = RIM_SNS_SHUT
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // avalon-mm register slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // function requests from on-chip controllers
    input wire logic [RIM_SRC_ENTRIES-1:0] source_shutter_req,
    input wire logic [N_SNS_SHUT-1:0] sensor_shutter_req,
    input wire logic [N_RELAY-1:0] logic_relay_req,
    // physical pins
    input wire logic [N_INPUT-1:0] phys_in,
    output logic [N_RELAY-1:0] relay_out,
    // logical results
    output logic [N_INPUT-1:0] input_func,
    output logic [N_RELAY-1:0] relay_stat
);

    localparam int RW = $clog2(N_RELAY);
    localparam int IW = $clog2(N_INPUT);

    // the sensor reset constant bounds how many sensor shutters can be kept
    if (N_RELAY != (1 << RW) || N_RELAY > 16 || N_RELAY < RIM_SNS_RELAY_BASE + N_SNS_SHUT
        || N_INPUT != (1 << IW) || N_INPUT > 16 || N_INPUT < 2
        || N_SRC_OUT > RIM_SRC_ENTRIES || N_SRC_OUT > RIM_SNS_RELAY_BASE || N_SNS_SHUT < 1
        || N_SNS_SHUT > $bits(RIM_SNS_EN_RST))
    begin : g_bad_param
        $error("rim relay, input or shutter counts do not fit the maps and relay slots");
    end

    typedef struct packed {
        logic [N_RELAY-1:0][RW-1:0] relay_map;
        logic [N_INPUT-1:0][IW-1:0] input_map;
        logic [N_RELAY-1:0] nc_sense;
        logic [N_INPUT-1:0] level_high;
        logic [RIM_SRC_ENTRIES-1:0] src_en;
        logic [N_SNS_SHUT-1:0] sns_en;
        logic [N_RELAY-1:0] logic_claim;
        logic conflict;
        logic [N_RELAY-1:0] relay_out;
        logic [N_RELAY-1:0] relay_stat;
        logic [N_INPUT-1:0] input_func;
        logic waitreq;
        logic [31:0] rdata;
    } rim_state_t;

    function automatic rim_state_t rst_state();
        rim_state_t s;
        s = '0;
        for (int k = 0; k < N_RELAY; k++)
        begin
            s.relay_map[k] = RW'(k);
        end
        for (int i = 0; i < N_INPUT; i++)
        begin
            s.input_map[i] = IW'(i);
        end
        s.nc_sense = RIM_RELAY_SENSE_RST[N_RELAY-1:0];
        s.level_high = RIM_INPUT_LEVEL_RST[N_INPUT-1:0];
        s.src_en = RIM_SRC_EN_RST;
        s.sns_en = RIM_SNS_EN_RST[N_SNS_SHUT-1:0];
        s.logic_claim = RIM_LOGIC_CLAIM_RST[N_RELAY-1:0];
        s.waitreq = 1'b1;
        s.rdata = RIM_RDATA_RST;
        return s;
    endfunction

    localparam rim_state_t ST_RST = rst_state();

    rim_state_t st_reg, st_next;

    logic [N_INPUT-1:0] in_sync;
    logic [N_RELAY-1:0][1:0] relay_owner;
    logic [N_RELAY-1:0] src_own, src_drv, sns_own, sns_drv;
    logic [N_RELAY-1:0] owned, drv, eff;
    logic [N_INPUT-1:0] in_sel;
    logic [N_RELAY-1:0] phys;
    logic dup_now;
    logic take, fire_wr;
    logic is_rmap, is_imap, ent_ok_r, ent_ok_i;
    logic [3:0] entry;
    logic [31:0] bemask, rd_word, wmerged;
    logic wr_conflict;

    rim_sync #(.W(N_INPUT)) rim_sync_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(phys_in),
        .sync_out(in_sync)
    );

    // owner and drive per logical relay; shutter claims beat logic claims
    for (genvar k = 0; k < N_RELAY; k++)
    begin : g_rel
        if (k >= RIM_FIRST_EVAPORATOR_SHUTTER_RELAY && k < RIM_FIRST_EVAPORATOR_SHUTTER_RELAY + N_SRC_OUT)
        begin : g_src
            // source entries past the physical outputs have no slot
            assign src_own[k] = st_reg.src_en[k - RIM_FIRST_EVAPORATOR_SHUTTER_RELAY];
            assign src_drv[k] = source_shutter_req[k - RIM_FIRST_EVAPORATOR_SHUTTER_RELAY];
        end
        else
        begin : g_nsrc
            assign src_own[k] = 1'b0;
            assign src_drv[k] = 1'b0;
        end
        if (k >= RIM_SNS_RELAY_BASE && k < RIM_SNS_RELAY_BASE + N_SNS_SHUT)
        begin : g_sns
            assign sns_own[k] = st_reg.sns_en[k - RIM_SNS_RELAY_BASE];
            assign sns_drv[k] = sensor_shutter_req[k - RIM_SNS_RELAY_BASE];
        end
        else
        begin : g_nsns
            assign sns_own[k] = 1'b0;
            assign sns_drv[k] = 1'b0;
        end
        assign relay_owner[k] = src_own[k] ? RIM_OWN_SOURCE :
                                sns_own[k] ? RIM_OWN_SENSOR :
                                st_reg.logic_claim[k] ? RIM_OWN_LOGIC : RIM_OWN_UNUSED;
        assign owned[k] = relay_owner[k] != RIM_OWN_UNUSED;
        assign drv[k] = src_own[k] ? src_drv[k] : sns_own[k] ? sns_drv[k] : st_reg.logic_claim[k] & logic_relay_req[k];
        // an unowned relay stays open whatever its sense
        assign eff[k] = owned[k] & (drv[k] ^ st_reg.nc_sense[k]);
    end

    // inputs: pin equal to the active level means asserted
    for (genvar i = 0; i < N_INPUT; i++)
    begin : g_in
        assign in_sel[i] = ~(in_sync[st_reg.input_map[i]] ^ st_reg.level_high[i]);
    end

    // lowest owned logical relay wins a shared physical index
    always_comb
    begin
        phys = '0;
        for (int p = 0; p < N_RELAY; p++)
        begin
            for (int k = N_RELAY - 1; k >= 0; k--)
            begin
                if (owned[k] && st_reg.relay_map[k] == RW'(p))
                begin
                    phys[p] = eff[k];
                end
            end
        end
    end

    always_comb
    begin
        dup_now = 1'b0;
        for (int k = 1; k < N_RELAY; k++)
        begin
            for (int j = 0; j < k; j++)
            begin
                if (owned[k] && owned[j] && st_reg.relay_map[k] == st_reg.relay_map[j])
                begin
                    dup_now = 1'b1;
                end
            end
        end
    end

    // bus decode: one wait cycle, then a single-cycle release
    assign take = st_reg.waitreq & (avs_read | avs_write);
    assign fire_wr = ~st_reg.waitreq & avs_write;
    assign is_rmap = avs_address[7:6] == RIM_OFS_RELAY_MAP[7:6];
    assign is_imap = avs_address[7:6] == RIM_OFS_INPUT_MAP[7:6];
    assign entry = avs_address[5:2];
    assign ent_ok_r = 32'(entry) < N_RELAY;
    assign ent_ok_i = 32'(entry) < N_INPUT;
    assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // readback doubles as the old value for byte-lane merging
    assign wmerged = (rd_word & ~bemask) | (avs_writedata & bemask);

    always_comb
    begin
        rd_word = 32'h0000_0000;
        // an out-of-range map entry falls through to the case and reads zero
        if (is_rmap && ent_ok_r)
        begin
            rd_word[RW-1:0] = st_reg.relay_map[entry[RW-1:0]];
        end
        else if (is_imap && ent_ok_i)
        begin
            rd_word[IW-1:0] = st_reg.input_map[entry[IW-1:0]];
        end
        else
        begin
            unique case (avs_address)
                RIM_OFS_RELAY_SENSE: rd_word[N_RELAY-1:0] = st_reg.nc_sense;
                RIM_OFS_INPUT_LEVEL: rd_word[N_INPUT-1:0] = st_reg.level_high;
                RIM_OFS_SOURCE_CFG:
                begin
                    rd_word[RIM_SRC_EN_LSB +: RIM_SRC_ENTRIES] = st_reg.src_en;
                    rd_word[RIM_SNS_EN_LSB +: N_SNS_SHUT] = st_reg.sns_en;
                end
                RIM_OFS_LOGIC_CLAIM: rd_word[N_RELAY-1:0] = st_reg.logic_claim;
                RIM_OFS_RELAY_STATUS: rd_word[N_RELAY-1:0] = st_reg.relay_stat;
                RIM_OFS_INPUT_STATUS: rd_word[N_INPUT-1:0] = st_reg.input_func;
                RIM_OFS_OWNER: rd_word[2*N_RELAY-1:0] = relay_owner;
                RIM_OFS_ERROR: rd_word[RIM_ERR_CONFLICT_BIT] = st_reg.conflict;
                RIM_OFS_PHYS_RELAY: rd_word[N_RELAY-1:0] = st_reg.relay_out;
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    // a map write that lands on an index held by another owner is dropped
    always_comb
    begin
        wr_conflict = 1'b0;
        if (fire_wr && is_rmap && ent_ok_r)
        begin
            for (int j = 0; j < N_RELAY; j++)
            begin
                if (j != 32'(entry) && owned[j] && st_reg.relay_map[j] == wmerged[RW-1:0])
                begin
                    wr_conflict = 1'b1;
                end
            end
        end
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.waitreq = ~take;
        if (take)
        begin
            st_next.rdata = rd_word;
        end
        if (fire_wr)
        begin
            if (is_rmap && ent_ok_r && !wr_conflict)
            begin
                st_next.relay_map[entry[RW-1:0]] = wmerged[RW-1:0];
            end
            else if (is_imap && ent_ok_i)
            begin
                st_next.input_map[entry[IW-1:0]] = wmerged[IW-1:0];
            end
            else
            begin
                // owner and status words ignore writes
                unique case (avs_address)
                    RIM_OFS_RELAY_SENSE: st_next.nc_sense = wmerged[N_RELAY-1:0];
                    RIM_OFS_INPUT_LEVEL: st_next.level_high = wmerged[N_INPUT-1:0];
                    RIM_OFS_SOURCE_CFG:
                    begin
                        // all four entries are kept even though two reach no relay
                        st_next.src_en = wmerged[RIM_SRC_EN_LSB +: RIM_SRC_ENTRIES];
                        st_next.sns_en = wmerged[RIM_SNS_EN_LSB +: N_SNS_SHUT];
                    end
                    RIM_OFS_LOGIC_CLAIM: st_next.logic_claim = wmerged[N_RELAY-1:0];
                    RIM_OFS_ERROR:
                    begin
                        if (avs_writedata[RIM_ERR_CONFLICT_BIT] && avs_byteenable[0])
                        begin
                            st_next.conflict = 1'b0;
                        end
                    end
                    default: st_next.conflict = st_reg.conflict;
                endcase
            end
        end
        // set after clear so a fresh conflict is never lost
        if (dup_now || wr_conflict)
        begin
            st_next.conflict = 1'b1;
        end
        // contacts, status and inputs all move together on the next edge
        st_next.relay_out = phys;
        st_next.relay_stat = owned & drv;
        st_next.input_func = in_sel;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_reg <= ST_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign relay_out = st_reg.relay_out;
    assign input_func = st_reg.input_func;
    assign relay_stat = st_reg.relay_stat;

    a_relay_route: assert property (@(posedge sys_clk) disable iff (rst)
        eff[0] |=> relay_out[$past(st_reg.relay_map[0])])
        else $error("owned relay 0 did not close its mapped contact");
    a_break_sense: assert property (@(posedge sys_clk) disable iff (rst)
        (owned[0] && st_reg.nc_sense[0] && !drv[0]) |=> (relay_out[$past(st_reg.relay_map[0])] && !relay_stat[0]))
        else $error("break sense relay not closed while idle");
    a_reset_open: assert property (@(posedge sys_clk) rst |=> (relay_out == '0))
        else $error("relay closed after reset");
    a_unused_open: assert property (@(posedge sys_clk) disable iff (rst) (owned == '0) |=> (relay_out == '0))
        else $error("relay closed with no owner");
    a_map_reject: assert property (@(posedge sys_clk) disable iff (rst)
        wr_conflict |=> ($stable(st_reg.relay_map) && st_reg.conflict))
        else $error("conflicting relay map write was accepted");
    a_owner_fixed: assert property (@(posedge sys_clk) disable iff (rst)
        ($stable(st_reg.src_en) && $stable(st_reg.sns_en) && $stable(st_reg.logic_claim)) |-> $stable(relay_owner))
        else $error("relay owner changed without a configuration change");
    a_src_owner: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.src_en[0] |-> (relay_owner[RIM_FIRST_EVAPORATOR_SHUTTER_RELAY] == RIM_OWN_SOURCE))
        else $error("enabled source shutter does not own its relay");
    a_input_level: assert property (@(posedge sys_clk) disable iff (rst)
        (in_sync[st_reg.input_map[0]] == st_reg.level_high[0]) |=> input_func[0])
        else $error("input at its active level not asserted");
    a_input_idle: assert property (@(posedge sys_clk) disable iff (rst)
        (in_sync[st_reg.input_map[0]] != st_reg.level_high[0]) |=> !input_func[0])
        else $error("input away from its active level asserted");
    a_status_read: assert property (@(posedge sys_clk) disable iff (rst)
        (take && avs_address == RIM_OFS_INPUT_STATUS) |=> (avs_readdata[N_INPUT-1:0] == $past(input_func)))
        else $error("input status readback does not match live inputs");
    a_no_phantom: assert property (@(posedge sys_clk) disable iff (rst)
        relay_owner[RIM_SNS_RELAY_BASE] != RIM_OWN_SOURCE)
        else $error("source entry without output claimed a relay");
    a_reset_map: assert property (@(posedge sys_clk)
        rst |=> (st_reg.relay_map[1] == RW'(1) && st_reg.input_map[1] == IW'(1)
                 && st_reg.nc_sense == '0 && st_reg.level_high == '0))
        else $error("reset configuration wrong");
    a_sense_edge: assert property (@(posedge sys_clk) disable iff (rst)
        (fire_wr && avs_address == RIM_OFS_RELAY_SENSE && avs_byteenable == 4'hF)
        |=> (st_reg.nc_sense == $past(wmerged[N_RELAY-1:0])))
        else $error("sense write not applied at the accepting edge");
    a_bus_pulse: assert property (@(posedge sys_clk) disable iff (rst) !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest held low for more than one cycle");

endmodule

// ==== hw/rim_pkg.sv ====
package rim_pkg;

    // function counts
    localparam int RIM_NFUNC = 16;
    localparam int RIM_SRC_ENTRIES = 4;
    localparam int RIM_SRC_OUTS = 2;
    localparam int RIM_SNS_SHUT = 2;

    // logical relay slots claimed by source and sensor shutters
    localparam int RIM_FIRST_EVAPORATOR_SHUTTER_RELAY = 0;
    localparam int RIM_SNS_RELAY_BASE = 2;

    // byte offsets on the register bus
    localparam logic [7:0] RIM_OFS_RELAY_MAP = 8'h00;
    localparam logic [7:0] RIM_OFS_INPUT_MAP = 8'h40;
    localparam logic [7:0] RIM_OFS_RELAY_SENSE = 8'h80;
    localparam logic [7:0] RIM_OFS_INPUT_LEVEL = 8'h84;
    localparam logic [7:0] RIM_OFS_SOURCE_CFG = 8'h88;
    localparam logic [7:0] RIM_OFS_LOGIC_CLAIM = 8'h8C;
    localparam logic [7:0] RIM_OFS_RELAY_STATUS = 8'h90;
    localparam logic [7:0] RIM_OFS_INPUT_STATUS = 8'h94;
    localparam logic [7:0] RIM_OFS_OWNER = 8'h98;
    localparam logic [7:0] RIM_OFS_ERROR = 8'h9C;
    localparam logic [7:0] RIM_OFS_PHYS_RELAY = 8'hA0;

    // field positions
    localparam int RIM_SRC_EN_LSB = 0;
    localparam int RIM_SNS_EN_LSB = 8;
    localparam int RIM_ERR_CONFLICT_BIT = 0;

    // reset values
    localparam logic [15:0] RIM_RELAY_SENSE_RST = 16'h0000;
    localparam logic [15:0] RIM_INPUT_LEVEL_RST = 16'h0000;
    localparam logic [15:0] RIM_LOGIC_CLAIM_RST = 16'h0000;
    localparam logic [3:0] RIM_SRC_EN_RST = 4'h0;
    localparam logic [1:0] RIM_SNS_EN_RST = 2'h0;
    localparam logic [31:0] RIM_RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        RIM_OWN_UNUSED = 2'b00,
        RIM_OWN_SENSOR = 2'b01,
        RIM_OWN_SOURCE = 2'b10,
        RIM_OWN_LOGIC = 2'b11
    } rim_owner_t;

endpackage

// ==== hw/rim_sync.sv ====
`timescale 1ns/10ps

module rim_sync
    import rim_pkg::*;
#(
    parameter int W = RIM_NFUNC
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pins and their synchronised copy
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } rim_sync_state_t;

    rim_sync_state_t st_reg, st_next;

    if (W < 1)
    begin : g_bad_width
        $error("rim_sync width must be at least one");
    end

    // meta feeds only the second stage
    always_comb
    begin
        st_next.meta = async_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.stable;

endmodule

// ==== verif/rim_equipment.sv ====
`timescale 1ns/10ps

module rim_equipment
    import rim_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // contacts seen and pins driven
    input wire logic [RIM_NFUNC-1:0] relay_out,
    input wire logic [RIM_NFUNC-1:0] pin_pattern,
    output logic [RIM_NFUNC-1:0] phys_in,
    output logic [RIM_NFUNC-1:0] contact_seen
);
    // a pin reads 1 for 5 V and 0 for 0 V; the equipment drives every pin, none float
    // pins are unknown only before the first edge, which falls inside reset
    always @(posedge sys_clk)
    begin
        phys_in <= pin_pattern;
    end
    // 1 means the contact pair is closed
    assign contact_seen = relay_out;
endmodule

// ==== verif/rim_relay_input_mapper_tb.sv ====
`timescale 1ns/10ps

module rim_relay_input_mapper_tb
    import rim_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] source_shutter_req = '0;
    logic [1:0] sensor_shutter_req = '0;
    logic [15:0] logic_relay_req = '0;
    logic [15:0] phys_in;
    logic [15:0] relay_out;
    logic [15:0] input_func;
    logic [15:0] relay_stat;
    logic [15:0] pin_pattern = '0;
    logic [15:0] contact_seen;
    logic [15:0] lvl;
    logic [31:0] exp_q[$];
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 32'h9c19_eef8;

    always #4 sys_clk = ~sys_clk;

    rim_relay_input_mapper rim_relay_input_mapper_inst (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .source_shutter_req(source_shutter_req), .sensor_shutter_req(sensor_shutter_req),
        .logic_relay_req(logic_relay_req), .phys_in(phys_in), .relay_out(relay_out),
        .input_func(input_func), .relay_stat(relay_stat)
    );

    rim_equipment rim_equipment_inst (
        .sys_clk(sys_clk), .relay_out(relay_out), .pin_pattern(pin_pattern),
        .phys_in(phys_in), .contact_seen(contact_seen)
    );

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one avalon access; the read's expected word goes to the queue for the watcher
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        if (!wr)
            exp_q.push_back(d);
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge sys_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // read data are taken at the edge that sees waitrequest low
    always @(posedge sys_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
        begin
            if (exp_q.size() == 0)
                chk("unexpected read", 32'h0000_0001, 32'h0000_0000);
            else
                chk("avs_readdata", avs_readdata, exp_q.pop_front());
        end
    end

    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic pins(input logic [15:0] p, input logic [15:0] lv, input logic [3:0] moved);
        logic [15:0] e;
        @(posedge sys_clk);
        pin_pattern <= p;
        settle();
        for (int k = 0; k < 16; k++)
            e[k] = ((k == 4) ? p[moved] : p[k]) ~^ lv[k];
        chk("input_func", input_func, e);
        bus(1'b0, RIM_OFS_INPUT_STATUS, {16'h0000, e});
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk("relay_out", relay_out, 16'h0000);
        bus(1'b0, 8'h0C, 32'h0000_0003);
        bus(1'b0, 8'h44, 32'h0000_0001);
        bus(1'b0, RIM_OFS_RELAY_SENSE, 32'h0000_0000);
        bus(1'b0, RIM_OFS_INPUT_LEVEL, 32'h0000_0000);
        bus(1'b0, RIM_OFS_OWNER, 32'h0000_0000);
        bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
        bus(1'b0, 8'hFC, 32'h0000_0000);
        // logic statement owns relay 5, routed to physical 9
        bus(1'b1, 8'h14, 32'h0000_0009);
        bus(1'b1, RIM_OFS_LOGIC_CLAIM, 32'h0000_0020);
        logic_relay_req <= 16'h0020;
        settle();
        chk("relay_out", relay_out, 16'h0200);
        chk("relay_stat", relay_stat, 16'h0020);
        bus(1'b0, RIM_OFS_PHYS_RELAY, 32'h0000_0200);
        bus(1'b1, RIM_OFS_RELAY_SENSE, 32'h0000_0020);
        settle();
        chk("contact_seen", contact_seen, 16'h0000);
        @(posedge sys_clk);
        logic_relay_req <= 16'h0000;
        settle();
        chk("relay_out", relay_out, 16'h0200);
        chk("relay_stat", relay_stat, 16'h0000);
        // all four sources and sensor 1 enabled; sources 3 and 4 own nothing
        bus(1'b1, RIM_OFS_SOURCE_CFG, 32'h0000_010F);
        source_shutter_req <= 4'hC;
        settle();
        chk("relay_out", relay_out, 16'h0200);
        @(posedge sys_clk);
        source_shutter_req <= 4'h1;
        sensor_shutter_req <= 2'b01;
        settle();
        chk("relay_out", relay_out, 16'h0205);
        chk("relay_stat", relay_stat, 16'h0005);
        bus(1'b0, RIM_OFS_RELAY_STATUS, 32'h0000_0005);
        bus(1'b0, RIM_OFS_OWNER, 32'h0000_0C1A);
        bus(1'b1, RIM_OFS_OWNER, 32'hFFFF_FFFF);
        bus(1'b0, RIM_OFS_OWNER, 32'h0000_0C1A);
        // relay 5 may not move onto the source-owned physical relay 0
        bus(1'b1, 8'h14, 32'h0000_0000);
        bus(1'b0, 8'h14, 32'h0000_0009);
        bus(1'b0, RIM_OFS_ERROR, 32'h0000_0001);
        bus(1'b1, RIM_OFS_ERROR, 32'h0000_0001);
        bus(1'b0, RIM_OFS_ERROR, 32'h0000_0000);
        #1;
        chk("relay_out", relay_out, 16'h0205);
        bus(1'b1, RIM_OFS_LOGIC_CLAIM, 32'h0000_0000);
        bus(1'b1, RIM_OFS_SOURCE_CFG, 32'h0000_0000);
        settle();
        chk("relay_out", relay_out, 16'h0000);
        // relay 5 parked on physical 0 while unowned; owning both later shares the index
        bus(1'b1, 8'h14, 32'h0000_0000);
        bus(1'b1, RIM_OFS_SOURCE_CFG, 32'h0000_0001);
        bus(1'b1, RIM_OFS_LOGIC_CLAIM, 32'h0000_0020);
        source_shutter_req <= 4'h0;
        settle();
        // break relay 5 would close, but the lower logical relay 0 keeps the contact open
        chk("contact_seen", contact_seen, 16'h0000);
        bus(1'b0, RIM_OFS_ERROR, 32'h0000_0001);
        bus(1'b1, RIM_OFS_LOGIC_CLAIM, 32'h0000_0000);
        bus(1'b1, RIM_OFS_SOURCE_CFG, 32'h0000_0000);
        // inputs: default active-low, then random levels with input 4 moved to pin 11
        for (int i = 0; i < 6; i++)
            pins(16'($random(seed)), 16'h0000, 4'd4);
        lvl = 16'($random(seed));
        bus(1'b1, RIM_OFS_INPUT_LEVEL, {16'h0000, lvl});
        // lane 1 only: the upper eight inputs fall back to active low, the lower keep theirs
        avs_byteenable <= 4'h2;
        bus(1'b1, RIM_OFS_INPUT_LEVEL, 32'hFFFF_0000);
        avs_byteenable <= 4'hF;
        lvl[15:8] = 8'h00;
        bus(1'b0, RIM_OFS_INPUT_LEVEL, {16'h0000, lvl});
        bus(1'b1, 8'h50, 32'h0000_000B);
        for (int i = 0; i < 6; i++)
            pins(16'($random(seed)), lvl, 4'd11);
        // second reset restores identity maps
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, 8'h50, 32'h0000_0004);
        bus(1'b0, 8'h14, 32'h0000_0005);
        repeat (3) @(posedge sys_clk);
        end_of_test();
    end
endmodule
